/* core/vipr_resolver.sv */
// Vectored interrupt priority resolver and service state tracker.
`timescale 1ns/100ps
`default_nettype none
module vipr_resolver #(
   parameter int NUM_VEC = vipr_pkg::NUM_VEC,
   parameter int VEC_W = vipr_pkg::VEC_W,
   parameter logic [NUM_VEC-1:0] HW_CLEAR_MASK = '0,
   parameter logic [NUM_VEC-1:0] SUMMARY_MASK = '0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [NUM_VEC-1:0] i_flag_set,
   input wire logic [NUM_VEC-1:0] i_summary_flags,
   input wire logic [NUM_VEC-1:0] i_flag_wr_en,
   input wire logic [NUM_VEC-1:0] i_flag_wr_data,
   input wire logic [NUM_VEC-1:0] i_enable,
   input wire logic i_prio_wr,
   input wire logic [NUM_VEC-1:0] i_prio_wr_data,
   input wire logic i_priority_levels_enable,
   input wire logic i_global_enable_high,
   input wire logic i_global_enable_low,
   input wire logic i_ack,
   input wire logic i_return_from_isr_instr,
   output logic [NUM_VEC-1:0] o_interrupt_flag_regs,
   output logic [NUM_VEC-1:0] o_priority_select_regs,
   output vipr_pkg::vipr_req_type o_req,
   output logic [VEC_W-1:0] o_working_register,
   output logic o_working_register_wr,
   output logic [2:0] o_state,
   output logic o_in_service_high,
   output logic o_in_service_low
);
   // Sources that exist in this map; the unused top range is never requested.
   function automatic logic [NUM_VEC-1:0] valid_map();
      logic [NUM_VEC-1:0] m;
      m = '1;
      for (int i = 0; i < NUM_VEC; i++) begin
         if (VEC_W'(i) >= vipr_pkg::VEC_UNUSED_LO) begin
            m[i] = 1'b0;
         end
      end
      return m;
   endfunction

   // Vector of a DMA or SPI channel event, base plus event offset.
   function automatic logic [VEC_W-1:0] dma_vec(input logic [VEC_W-1:0] base,
                                                input logic [VEC_W-1:0] ofs);
      return VEC_W'(base + ofs);
   endfunction

   localparam logic [NUM_VEC-1:0] VMAP = valid_map();

   // Named source vectors, referenced only by V_CHECK at the end of this module.
   localparam logic [VEC_W-1:0] V_DMA1_SRC = dma_vec(vipr_pkg::VEC_DMA1, vipr_pkg::DMA_OFS_SRC);
   localparam logic [VEC_W-1:0] V_DMA1_ABT = dma_vec(vipr_pkg::VEC_DMA1, vipr_pkg::DMA_OFS_ABT);
   localparam logic [VEC_W-1:0] V_DMA2_SRC = dma_vec(vipr_pkg::VEC_DMA2, vipr_pkg::DMA_OFS_SRC);
   localparam logic [VEC_W-1:0] V_DMA3_SRC = dma_vec(vipr_pkg::VEC_DMA3, vipr_pkg::DMA_OFS_SRC);
   localparam logic [VEC_W-1:0] V_SPI1_GEN = dma_vec(vipr_pkg::VEC_SPI1, vipr_pkg::SPI_OFS_GEN);
   localparam logic [VEC_W-1:0] V_SPI2_RX = dma_vec(vipr_pkg::VEC_SPI2, vipr_pkg::SPI_OFS_RX);

   vipr_pkg::vipr_state_type state_q;
   vipr_pkg::vipr_state_type state_d;
   logic [NUM_VEC-1:0] flag_q;
   logic [NUM_VEC-1:0] prio_q;
   logic gen_q;
   logic gel_q;
   logic gie_changed;
   logic low_nested_q;
   logic [NUM_VEC-1:0] pending;
   logic [NUM_VEC-1:0] pend_high;
   logic [NUM_VEC-1:0] pend_low;
   vipr_pkg::vipr_win_type win_high;
   vipr_pkg::vipr_win_type win_low;
   vipr_pkg::vipr_req_type req_d;
   logic [NUM_VEC-1:0] hw_clr;
   logic [NUM_VEC-1:0] sticky_view;

   // Pending means the flag reads one, the source is enabled and it exists.
   assign sticky_view = (flag_q & ~SUMMARY_MASK) | (i_summary_flags & SUMMARY_MASK);
   assign pending = sticky_view & i_enable & VMAP;

   // Without levels every source is treated as high; one shared level.
   assign pend_high = i_priority_levels_enable ? (pending & prio_q) : pending;
   assign pend_low = i_priority_levels_enable ? (pending & ~prio_q) : '0;

   vipr_find #(
      .N(NUM_VEC),
      .W(VEC_W)
   ) u_find_high (
      .i_req(pend_high),
      .o_win(win_high)
   );

   vipr_find #(
      .N(NUM_VEC),
      .W(VEC_W)
   ) u_find_low (
      .i_req(pend_low),
      .o_win(win_low)
   );

   // Global enables are sampled so that software edits are seen as changes.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         // Track the live level in reset so release does not look like a software edit.
         gen_q <= i_global_enable_high;
         gel_q <= i_global_enable_low;
      end else begin
         gen_q <= i_global_enable_high;
         gel_q <= i_global_enable_low;
      end
   end

   // Only software moves the enables; this block never writes them.
   assign gie_changed = (gen_q != i_global_enable_high) || (gel_q != i_global_enable_low);

   // Select the request offered in the present state.
   always_comb begin
      req_d = '0;
      unique case (state_q)
         vipr_pkg::VIPR_MAIN: begin
            if (i_global_enable_high && win_high.valid) begin
               req_d = {1'b1, 1'b1, win_high.vec};
            end else if (i_global_enable_high && i_global_enable_low && win_low.valid) begin
               req_d = {1'b1, 1'b0, win_low.vec};
            end
         end
         vipr_pkg::VIPR_LOW: begin
            if (i_global_enable_high && win_high.valid) begin
               req_d = {1'b1, 1'b1, win_high.vec};
            end
         end
         vipr_pkg::VIPR_HIGH: begin
            req_d = '0;
         end
         default: begin
            req_d = '0;
         end
      endcase
      if (gie_changed) begin
         req_d = '0;
      end
   end

   // Next execution state from acknowledges, returns and enable edits.
   always_comb begin
      state_d = state_q;
      if (gie_changed) begin
         state_d = vipr_pkg::VIPR_MAIN;
      end else if (i_ack && o_req.valid) begin
         state_d = o_req.high ? vipr_pkg::VIPR_HIGH : vipr_pkg::VIPR_LOW;
      end else if (i_return_from_isr_instr) begin
         unique case (state_q)
            vipr_pkg::VIPR_HIGH: begin
               // A low routine stays marked until its own return.
               state_d = low_nested_q ? vipr_pkg::VIPR_LOW : vipr_pkg::VIPR_MAIN;
            end
            vipr_pkg::VIPR_LOW: begin
               state_d = vipr_pkg::VIPR_MAIN;
            end
            vipr_pkg::VIPR_MAIN: begin
               state_d = vipr_pkg::VIPR_MAIN;
            end
            default: begin
               state_d = vipr_pkg::VIPR_MAIN;
            end
         endcase
      end
   end

   // Remembers that a high routine preempted a low one.
   always_ff @(posedge i_clk) begin
      if (i_rst || gie_changed) begin
         low_nested_q <= 1'b0;
      end else if (i_ack && o_req.valid && o_req.high) begin
         low_nested_q <= (state_q == vipr_pkg::VIPR_LOW);
      end else if (i_return_from_isr_instr && state_q == vipr_pkg::VIPR_HIGH) begin
         low_nested_q <= 1'b0;
      end
   end

   // Execution state register.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= vipr_pkg::VIPR_MAIN;
      end else begin
         state_q <= state_d;
      end
   end

   // Hardware clears the flag of an auto-clear source on its acknowledge.
   always_comb begin
      hw_clr = '0;
      if (i_ack && o_req.valid) begin
         hw_clr[o_req.vec] = HW_CLEAR_MASK[o_req.vec];
      end
   end

   // Flags other than summary bits are sticky; a new set wins over a clear in the same cycle.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         flag_q <= vipr_pkg::FLAG_RESET;
      end else begin
         for (int i = 0; i < NUM_VEC; i++) begin
            if (i_flag_set[i] && !SUMMARY_MASK[i]) begin
               flag_q[i] <= 1'b1;
            end else if (SUMMARY_MASK[i]) begin
               flag_q[i] <= 1'b0;
            end else if (hw_clr[i]) begin
               flag_q[i] <= 1'b0;
            end else if (i_flag_wr_en[i]) begin
               flag_q[i] <= i_flag_wr_data[i];
            end
         end
      end
   end

   // Priority selects; every source starts at the high level.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prio_q <= {NUM_VEC{vipr_pkg::PRIO_RESET}};
      end else if (i_prio_wr) begin
         prio_q <= i_prio_wr_data;
      end
   end

   // Winner is registered once per instruction cycle for the sequencer.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_req <= '0;
      end else begin
         o_req <= req_d;
      end
   end

   // Vector number goes to the working register when vectoring.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_working_register <= '0;
         o_working_register_wr <= 1'b0;
      end else begin
         o_working_register_wr <= i_ack && o_req.valid && !gie_changed;
         if (i_ack && o_req.valid && !gie_changed) begin
            o_working_register <= o_req.vec;
         end
      end
   end

   // Readable state and flag copies.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_state <= 3'h1;
         o_in_service_high <= 1'b0;
         o_in_service_low <= 1'b0;
         o_interrupt_flag_regs <= '0;
         o_priority_select_regs <= {NUM_VEC{vipr_pkg::PRIO_RESET}};
      end else begin
         o_state <= state_d;
         o_in_service_high <= (state_d == vipr_pkg::VIPR_HIGH);
         o_in_service_low <= (state_d == vipr_pkg::VIPR_LOW) || low_nested_q;
         o_interrupt_flag_regs <= sticky_view;
         o_priority_select_regs <= prio_q;
      end
   end

   // Named vectors are referenced so the map is fixed at elaboration.
   localparam logic [VEC_W-1:0] V_CHECK = V_DMA1_SRC ^ V_DMA1_ABT ^ V_DMA2_SRC
      ^ V_DMA3_SRC ^ V_SPI1_GEN ^ V_SPI2_RX ^ vipr_pkg::VEC_WAVE1 ^ vipr_pkg::VEC_OSC1
      ^ vipr_pkg::VEC_WAVE2 ^ vipr_pkg::VEC_CRC ^ vipr_pkg::VEC_TIMER6;
endmodule // vipr_resolver
`default_nettype wire

/* pkg/vipr_pkg.sv */
// Package with constants and carrier types for the interrupt priority resolver.
package vipr_pkg;
   localparam int NUM_VEC = 144;
   localparam int VEC_W = 8;
   localparam logic [VEC_W-1:0] VEC_TOP = 8'h8f;
   localparam logic [VEC_W-1:0] VEC_UNUSED_LO = 8'h7c;
   localparam logic [VEC_W-1:0] VEC_DMA1 = 8'h14;
   localparam logic [VEC_W-1:0] VEC_DMA2 = 8'h34;
   localparam logic [VEC_W-1:0] VEC_DMA3 = 8'h54;
   localparam logic [VEC_W-1:0] VEC_SPI1 = 8'h18;
   localparam logic [VEC_W-1:0] VEC_SPI2 = 8'h28;
   localparam logic [VEC_W-1:0] VEC_WAVE1 = 8'h32;
   localparam logic [VEC_W-1:0] VEC_OSC1 = 8'h33;
   localparam logic [VEC_W-1:0] VEC_WAVE2 = 8'h52;
   localparam logic [VEC_W-1:0] VEC_CRC = 8'h7a;
   localparam logic [VEC_W-1:0] VEC_TIMER6 = 8'h7b;
   localparam logic [VEC_W-1:0] DMA_OFS_SRC = 8'h00;
   localparam logic [VEC_W-1:0] DMA_OFS_DST = 8'h01;
   localparam logic [VEC_W-1:0] DMA_OFS_OVR = 8'h02;
   localparam logic [VEC_W-1:0] DMA_OFS_ABT = 8'h03;
   localparam logic [VEC_W-1:0] SPI_OFS_RX = 8'h00;
   localparam logic [VEC_W-1:0] SPI_OFS_TX = 8'h01;
   localparam logic [VEC_W-1:0] SPI_OFS_GEN = 8'h02;
   localparam logic PRIO_RESET = 1'b1;
   localparam logic [NUM_VEC-1:0] FLAG_RESET = '0;

   // Execution states, one-hot.
   typedef enum logic [2:0] {
      VIPR_MAIN = 3'b001,
      VIPR_LOW = 3'b010,
      VIPR_HIGH = 3'b100
   } vipr_state_type;

   // A resolved candidate from the priority search.
   typedef struct packed {
      logic valid;
      logic [VEC_W-1:0] vec;
   } vipr_win_type;

   // Request handed to the CPU sequencer.
   typedef struct packed {
      logic valid;
      logic high;
      logic [VEC_W-1:0] vec;
   } vipr_req_type;
endpackage

/* core/vipr_find.sv */
// Fixed natural-order search: lowest pending vector number wins.
`timescale 1ns/100ps
`default_nettype none
module vipr_find #(
   parameter int N = 144,
   parameter int W = 8
) (
   input wire logic [N-1:0] i_req,
   output vipr_pkg::vipr_win_type o_win
);
   // Scan downward so the smallest index is written last and wins.
   always_comb begin
      o_win = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (i_req[i]) begin
            o_win.valid = 1'b1;
            o_win.vec = W'(i);
         end
      end
   end
endmodule // vipr_find
`default_nettype wire

/* sim/vipr_resolver_chk.sv */
// Concurrent checks on the priority resolver ports.
`timescale 1ns/100ps
`default_nettype none
module vipr_resolver_chk #(
   parameter int NUM_VEC = vipr_pkg::NUM_VEC,
   parameter int VEC_W = vipr_pkg::VEC_W
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_global_enable_high,
   input wire logic i_global_enable_low,
   input wire logic i_ack,
   input wire logic i_return_from_isr_instr,
   input wire logic [NUM_VEC-1:0] o_priority_select_regs,
   input wire logic [NUM_VEC-1:0] o_interrupt_flag_regs,
   input wire vipr_pkg::vipr_req_type o_req,
   input wire logic [VEC_W-1:0] o_working_register,
   input wire logic o_working_register_wr,
   input wire logic [2:0] o_state
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // A taken request, and a state seen on two edges running.
   // An acknowledge in the cycle of an enable edit enters no service and writes no working register, but still clears an auto-clear flag.
   sequence s_take;
      i_ack && o_req.valid && !$changed(i_global_enable_high)
         && !$changed(i_global_enable_low);
   endsequence
   sequence s_held(st);
      o_state == st ##1 o_state == st;
   endsequence
   AST_TAKE_WORKING_REGISTER: assert property (s_take |=>
      o_working_register_wr && o_working_register == $past(o_req.vec))
      else $error("Working register missed the taken vector.");
   AST_TAKE_HIGH: assert property (s_take ##0 o_req.high |=> o_state == 3'h4)
      else $error("Taken high request did not enter high service.");
   AST_HIGH_QUIET: assert property (s_held(3'h4) |-> !o_req.valid)
      else $error("Request offered during high service.");
   AST_LOW_ONLY_HIGH: assert property (s_held(3'h2) |-> !o_req.valid || o_req.high)
      else $error("Low request offered during low service.");
   AST_ENABLE_MAIN: assert property (
      $changed(i_global_enable_high) || $changed(i_global_enable_low) |=> o_state == 3'h1)
      else $error("Enable change did not return to main.");
   AST_RET_HIGH: assert property (o_state == 3'h4 && i_return_from_isr_instr |=>
      o_state != 3'h4) else $error("Return left high service standing.");
   AST_PRIO_INIT: assert property ($past(i_rst) |-> &o_priority_select_regs)
      else $error("Priority selects not all high after reset.");
   AST_VEC_RANGE: assert property (o_req.valid |-> o_req.vec < 8'h7c)
      else $error("Unassigned vector requested.");
   AST_REQ_FLAGGED: assert property (o_req.valid |-> o_interrupt_flag_regs[o_req.vec])
      else $error("Request offered for a source whose flag reads zero.");
endmodule // vipr_resolver_chk
bind vipr_resolver vipr_resolver_chk #(.NUM_VEC(NUM_VEC), .VEC_W(VEC_W)) u_chk (.*);
`default_nettype wire

/* sim/vipr_cpu_model.sv */
// Behavioural instruction sequencer that takes requests and returns from routines.
`timescale 1ns/100ps
`default_nettype none
module vipr_cpu_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire vipr_pkg::vipr_req_type i_req,
   input wire logic [2:0] i_state,
   input wire logic [7:0] i_svc_len,
   output logic o_ack,
   output logic o_ret,
   output logic [143:0] o_clr
);
   logic [1:0] gap_q;
   logic [7:0] cnt_q;
   logic [2:0] state_q;
   // Takes a standing request at once; the gap keeps a stale winner from being taken twice.
   assign o_ack = !i_rst && i_req.valid === 1'b1 && gap_q == 2'h0;
   // Software clears the taken flag in the routine's first cycle.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_clr <= '0;
         gap_q <= 2'h0;
      end else begin
         o_clr <= '0;
         gap_q <= (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0;
         if (o_ack) begin
            o_clr[i_req.vec] <= 1'b1;
            gap_q <= 2'h3;
         end
      end
   end
   // Each routine runs for the set length in its state, then returns.
   always_ff @(posedge i_clk) begin
      state_q <= i_rst ? 3'h1 : i_state;
      o_ret <= 1'b0;
      if (i_rst || i_state != state_q || o_ret) begin
         cnt_q <= 8'h0;
      end else if (i_state != 3'h1) begin
         cnt_q <= cnt_q + 8'h1;
         o_ret <= (cnt_q == i_svc_len);
      end
   end
endmodule // vipr_cpu_model
`default_nettype wire

/* sim/test_vectored_interrupt_priority_resolver.sv */
// Self-checking bench for the vectored interrupt priority resolver.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
$display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module test_vectored_interrupt_priority_resolver;
   localparam logic [7:0] DOC[13] = '{8'h00, 8'h14, 8'h35, 8'h56, 8'h17, 8'h18, 8'h29,
      8'h1a, 8'h32, 8'h33, 8'h52, 8'h7a, 8'h7b};
   // The bench picks one auto-clearing source and one summary bit for the instance.
   localparam logic [7:0] HWC = 8'h7b;
   localparam logic [7:0] SUMC = 8'h80;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [143:0] fset = '0;
   logic [143:0] en = '1;
   logic [143:0] pdata = '1;
   logic [143:0] clr;
   logic [143:0] psel;
   logic [143:0] m;
   logic [143:0] flags;
   logic [143:0] sumf = '0;
   logic gel = 1'b1;
   logic shi;
   logic slo;
   logic last_wr = 1'b0;
   logic [7:0] last_vec = 8'h0;
   logic pwr = 1'b0;
   logic lev = 1'b0;
   logic geh = 1'b1;
   logic ack;
   logic ret;
   logic wr;
   logic [7:0] svc = 8'h0;
   logic [7:0] working_register;
   logic [2:0] st;
   vipr_pkg::vipr_req_type req;
   logic [10:0] exp_q[$];
   int errors = 0;
   int check_count = 0;
   vipr_resolver #(.HW_CLEAR_MASK(144'h1 << HWC), .SUMMARY_MASK(144'h1 << SUMC)) dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_flag_set(fset), .i_summary_flags(sumf),
      .i_flag_wr_en(clr), .i_flag_wr_data('0), .i_enable(en), .i_prio_wr(pwr),
      .i_prio_wr_data(pdata), .i_priority_levels_enable(lev), .i_global_enable_high(geh),
      .i_global_enable_low(gel), .i_ack(ack), .i_return_from_isr_instr(ret),
      .o_interrupt_flag_regs(flags), .o_priority_select_regs(psel), .o_req(req),
      .o_working_register(working_register), .o_working_register_wr(wr), .o_state(st),
      .o_in_service_high(shi), .o_in_service_low(slo));
   vipr_cpu_model cpu (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_state(st),
      .i_svc_len(svc), .o_ack(ack), .o_ret(ret), .o_clr(clr));
   // Free-running 100 MHz clock.
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   // Notes the state and vector expected at the next working register write.
   function automatic void note(input logic [2:0] s, input logic [7:0] v);
      exp_q.push_back({s, v});
   endfunction
   task automatic pulse(input logic [143:0] mk);
      fset <= mk;
      @(posedge i_clk);
      fset <= '0;
   endtask
   // Waits, bounded, for every note to be consumed and execution back in main.
   task automatic drain();
      int n;
      n = 0;
      while ((exp_q.size() != 0 || st !== 3'h1) && n < 2000) begin
         @(posedge i_clk);
         n++;
      end
      repeat (4) @(posedge i_clk);
      `CHECK("pending notes", 0, exp_q.size())
      `CHECK("state", 3'h1, st)
      `CHECK("high service", 1'b0, shi)
      `CHECK("low service", 1'b0, slo)
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Each working register write must match the oldest note; a write with none is a fault.
   always @(posedge i_clk) begin
      logic [10:0] e;
      // One cycle after vectoring only the auto-clearing source has dropped its flag.
      if (!i_rst && last_wr) begin
         `CHECK("auto clear flag", last_vec != HWC, flags[last_vec])
      end
      last_wr <= !i_rst && wr === 1'b1;
      last_vec <= working_register;
      if (!i_rst && wr === 1'b1) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 11'h7ff;
         `CHECK("working register", e[7:0], working_register)
         `CHECK("service state", e[10:8], st)
         `CHECK("high service", e[10:8] == 3'h4, shi)
         if (e[10:8] == 3'h2) `CHECK("low service", 1'b1, slo)
      end
   end
   // Whole sequence needs a few hundred cycles; this cuts a hang short.
   initial begin
      repeat (20000) @(posedge i_clk);
      errors++;
      complete_run();
   end
   initial begin
      void'($urandom(14555));
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      `CHECK("priority selects", {144{1'b1}}, psel)
      // One level: listed vectors plus a random one, served in rising order, fast then slow.
      for (int r = 0; r < 2; r++) begin
         m = '0;
         foreach (DOC[i]) m[DOC[i]] = 1'b1;
         m[$urandom_range(123, 0)] = 1'b1;
         m[8'h7c] = 1'b1;
         svc <= (r == 0) ? 8'h0 : 8'h9;
         for (int v = 0; v < 124; v++) if (m[v]) note(3'h4, 8'(v));
         pulse(m);
         drain();
      end
      // Two levels: high sources beat a lower-numbered low source.
      lev <= 1'b1;
      pdata[8'h05] <= 1'b0;
      pwr <= 1'b1;
      @(posedge i_clk);
      pwr <= 1'b0;
      repeat (2) @(posedge i_clk);
      `CHECK("priority selects", pdata, psel)
      note(3'h4, 8'h60);
      note(3'h4, 8'h70);
      note(3'h2, 8'h05);
      pulse((144'h1 << 8'h05) | (144'h1 << 8'h60) | (144'h1 << 8'h70));
      drain();
      // A high source preempts a running low routine, which then resumes.
      svc <= 8'h14;
      note(3'h2, 8'h05);
      note(3'h4, 8'h7b);
      pulse(144'h1 << 8'h05);
      repeat (8) @(posedge i_clk);
      pulse(144'h1 << 8'h7b);
      drain();
      // A disabled source and an unassigned vector wait; enabling the source lets it in.
      en[8'h40] <= 1'b0;
      pulse((144'h1 << 8'h40) | (144'h1 << 8'h7d) | (144'h1 << SUMC));
      repeat (20) @(posedge i_clk);
      `CHECK("summary flag", 1'b0, flags[SUMC])
      sumf[SUMC] <= 1'b1;
      repeat (2) @(posedge i_clk);
      `CHECK("summary flag", 1'b1, flags[SUMC])
      sumf[SUMC] <= 1'b0;
      note(3'h4, 8'h40);
      en[8'h40] <= 1'b1;
      drain();
      // A global enable change mid-routine drops execution back to main.
      note(3'h4, 8'h22);
      pulse(144'h1 << 8'h22);
      repeat (6) @(posedge i_clk);
      geh <= 1'b0;
      gel <= 1'b0;
      @(posedge i_clk);
      geh <= 1'b1;
      gel <= 1'b1;
      @(posedge i_clk);
      `CHECK("state", 3'h1, st)
      drain();
      complete_run();
   end
endmodule // test_vectored_interrupt_priority_resolver
`default_nettype wire
